// ===== core/sbx_core.sv
// Subtract instruction execution core
`timescale 1ns/10ps
`include "sbx_defines.svh"
module sbx_core (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Instruction entry
	input  wire logic          instr_valid,
	input  wire logic [15:0]   instr,
	output logic               instr_ready,
	output logic               done,
	output logic               illegal,
	// Bank select register load
	input  wire logic          bank_we,
	input  wire logic [3:0]    bank_wdata,
	// State
	output logic [7:0]         working_register,
	output logic [7:0]         status,
	output logic [3:0]         bank_select_register,
	// Debug read of data memory
	input  wire sbx_pkg::sbx_addr_t dbg_addr,
	output logic [7:0]         dbg_rdata
);
	import sbx_pkg::*;

	sbx_mem_if  mif ();
	sbx_phase_t phase;
	logic [15:0] ir;
	logic        busy;
	logic [7:0]  result;
	logic [7:0]  st_new;

	// ========================================
	// Decode
	wire is_lit  = ir[15:8] == `SBX_OP_LIT;
	wire is_file = ir[15:10] == `SBX_OP_FILE;
	wire is_fwb  = ir[15:10] == `SBX_OP_FBORROW;
	wire dest_f  = ir[9];
	wire acc_bit = ir[8];
	wire [7:0] f_low = ir[7:0];
	// Access bank: low half at bank 0, high half at bank 0xf
	wire [3:0] acc_bank = (f_low < `SBX_ACCESS_SPLIT) ? 4'h0 : `SBX_ACCESS_HI;
	wire [3:0] use_bank = acc_bit ? bank_select_register : acc_bank;
	wire [11:0] op_addr = {use_bank, f_low};

	// ========================================
	// Arithmetic: minuend minus subtrahend minus borrow
	wire [7:0] minu = is_lit ? ir[7:0] : (is_fwb ? working_register : mif.rdata);
	wire [7:0] subt = is_fwb ? mif.rdata : working_register;
	wire       bin  = is_fwb & ~status[`SBX_ST_C];
	wire [8:0] diff = {1'b0, minu} - {1'b0, subt} - {8'h00, bin};
	wire [4:0] ndif = {1'b0, minu[3:0]} - {1'b0, subt[3:0]} - {4'h0, bin};
	wire       ovf  = (minu[7] ^ subt[7]) & (minu[7] ^ diff[7]);

	// Flags; other status bits kept
	always_comb begin
		st_new = status;
		st_new[`SBX_ST_C]  = ~diff[8];
		st_new[`SBX_ST_DC] = ~ndif[4];
		st_new[`SBX_ST_Z]  = diff[7:0] == 8'h00;
		st_new[`SBX_ST_OV] = ovf;
		st_new[`SBX_ST_N]  = diff[7];
	end

	// Memory port
	wire legal = is_lit | is_file | is_fwb;
	wire wr_f  = (phase == SBX_Q4) & busy & ~is_lit & dest_f & legal;
	assign mif.addr  = wr_f ? op_addr : (busy ? op_addr : dbg_addr);
	assign mif.we    = wr_f;
	assign mif.wdata = result;
	assign instr_ready = ~busy;

	sbx_dmem u_dmem (
		.clk (clk),
		.mem (mif)
	);

	// ========================================
	// Four-phase sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy  <= 1'b0;
			phase <= SBX_Q1;
			ir    <= 16'h0000;
		end else if (!busy) begin
			if (instr_valid) begin
				busy  <= 1'b1;
				phase <= SBX_Q1;
				ir    <= instr;
			end
		end else begin
			unique case (phase)
				SBX_Q1: phase <= SBX_Q2;
				SBX_Q2: phase <= SBX_Q3;
				SBX_Q3: phase <= SBX_Q4;
				SBX_Q4: begin
					phase <= SBX_Q1;
					busy  <= 1'b0;
				end
			endcase
		end
	end

	// Result latched at Q3, written at Q4
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result           <= 8'h00;
			working_register <= `SBX_RST_W;
			status           <= `SBX_RST_ST;
			done             <= 1'b0;
			illegal          <= 1'b0;
			dbg_rdata        <= 8'h00;
		end else begin
			done      <= busy & (phase == SBX_Q4);
			illegal   <= busy & (phase == SBX_Q4) & ~legal;
			dbg_rdata <= busy ? dbg_rdata : mif.rdata;
			if (busy && phase == SBX_Q3) begin
				result <= diff[7:0];
			end
			if (busy && phase == SBX_Q4 && legal) begin
				status <= st_new;
				if (is_lit || !dest_f) begin
					working_register <= result;
				end
			end
		end
	end

	// Bank select register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_select_register <= `SBX_RST_BANK;
		end else if (bank_we) begin
			bank_select_register <= bank_wdata;
		end
	end

	// ========================================
	// Checks
	property p_done_after_four;
		@(posedge clk) disable iff (!rst_n)
		(instr_valid && instr_ready) |-> ##5 done;
	endproperty
	a_done_after_four: assert property (p_done_after_four)
		else $error("instruction did not finish in four phases");

	property p_lit_result;
		@(posedge clk) disable iff (!rst_n)
		(instr_valid && instr_ready && instr[15:8] == 8'h08)
		|-> ##5 working_register ==
			8'($past(instr[7:0], 5) - $past(working_register, 5));
	endproperty
	a_lit_result: assert property (p_lit_result)
		else $error("literal subtract result wrong");

	property p_zero_carry;
		@(posedge clk) disable iff (!rst_n)
		(done && !illegal && status[2]) |-> status[0] && !status[4];
	endproperty
	a_zero_carry: assert property (p_zero_carry)
		else $error("zero result without carry or with negative");

	property p_flag_hold;
		@(posedge clk) disable iff (!rst_n)
		!(busy && phase == SBX_Q4) |=> $stable(status);
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("status changed outside write phase");

	// Helpers: last phase of a legal word, result bound for W
	wire q4_legal = busy & (phase == SBX_Q4) & legal;
	wire q4_to_w  = q4_legal & (is_lit | ~dest_f);

	// Ready stays low through the four phases, then returns
	property p_ready_low;
		@(posedge clk) disable iff (!rst_n)
		(instr_valid && instr_ready)
		|=> !instr_ready [*4] ##1 instr_ready;
	endproperty
	a_ready_low: assert property (p_ready_low)
		else $error("ready not low for exactly four phases");

	// Next word may be offered while done stands
	property p_done_ready;
		@(posedge clk) disable iff (!rst_n)
		done |-> instr_ready;
	endproperty
	a_done_ready: assert property (p_done_ready)
		else $error("not ready while done stands");

	// Negative flag follows bit 7 of a result written to W
	property p_neg_bit;
		@(posedge clk) disable iff (!rst_n)
		q4_to_w |=> status[`SBX_ST_N] == working_register[7];
	endproperty
	a_neg_bit: assert property (p_neg_bit)
		else $error("negative flag differs from result bit 7");

	// Zero flag agrees with a result written to W
	property p_zero_flag;
		@(posedge clk) disable iff (!rst_n)
		q4_to_w |=> status[`SBX_ST_Z] == (working_register == 8'h00);
	endproperty
	a_zero_flag: assert property (p_zero_flag)
		else $error("zero flag differs from result");

	// A result bound for the file leaves W alone
	property p_file_keeps_w;
		@(posedge clk) disable iff (!rst_n)
		wr_f |=> $stable(working_register);
	endproperty
	a_file_keeps_w: assert property (p_file_keeps_w)
		else $error("file destination changed working register");

	// Unknown words flag illegal and change nothing
	property p_illegal_hold;
		@(posedge clk) disable iff (!rst_n)
		(busy && phase == SBX_Q4 && !legal)
		|=> illegal && $stable(working_register) && $stable(status);
	endproperty
	a_illegal_hold: assert property (p_illegal_hold)
		else $error("illegal word changed state or was not flagged");

	// Bank select register takes the loaded value
	property p_bank_load;
		@(posedge clk) disable iff (!rst_n)
		bank_we |=> bank_select_register == $past(bank_wdata);
	endproperty
	a_bank_load: assert property (p_bank_load)
		else $error("bank select register not loaded");
endmodule : sbx_core

// ===== core/sbx_defines.svh
// Constants for the subtract execution block
// Behaviour
// - Literal minus working register into working register
// - Literal form decoded from upper byte 0x08
// - Update N OV C DC Z only
// - One instruction cycle, four phases
// - File minus working register, top bits 010111
// - Destination bit: 0 working, 1 file
// - Access bit: 0 access bank, 1 bank select
// - No borrow sets carry; zero sets Z
// - Borrow wraps result, clears carry; N follows result bit 7
// - Borrow variant: working minus file minus borrow
`ifndef SBX_DEFINES_SVH
`define SBX_DEFINES_SVH
// ========================================
// Opcode fields
`define SBX_OP_LIT      8'h08
`define SBX_OP_FILE     6'h17
`define SBX_OP_FBORROW  6'h15
`define SBX_ACCESS_HI   4'hf
`define SBX_ACCESS_SPLIT 8'h80
// ========================================
// Status bit positions
`define SBX_ST_C   0
`define SBX_ST_DC  1
`define SBX_ST_Z   2
`define SBX_ST_OV  3
`define SBX_ST_N   4
// ========================================
// Reset values
`define SBX_RST_W     8'h00
`define SBX_RST_ST    8'h00
`define SBX_RST_BANK  4'h0
`define SBX_RST_MEM   8'h00
`endif

// ===== core/sbx_dmem.sv
// Data memory with registered read data
`timescale 1ns/10ps
`include "sbx_defines.svh"
module sbx_dmem (
	// Clock
	input wire logic clk,
	// Port
	sbx_mem_if.mem   mem
);
	// Powers up cleared so file operands start out known
	logic [7:0] store [0:4095] = '{default: `SBX_RST_MEM};

	// Write and registered read
	always_ff @(posedge clk) begin
		if (mem.we) begin
			store[mem.addr] <= mem.wdata;
		end
		mem.rdata <= store[mem.addr];
	end
endmodule : sbx_dmem

// ===== core/sbx_mem_if.sv
// Interface between the core and its data memory
`timescale 1ns/10ps
interface sbx_mem_if;
	logic [11:0] addr;
	logic [7:0]  rdata;
	logic        we;
	logic [7:0]  wdata;
	modport core (output addr, output we, output wdata, input rdata);
	modport mem  (input addr, input we, input wdata, output rdata);
endinterface : sbx_mem_if

// ===== core/sbx_pkg.sv
// Types for the subtract execution block
package sbx_pkg;
	typedef enum logic [1:0] {SBX_Q1, SBX_Q2, SBX_Q3, SBX_Q4} sbx_phase_t;
	typedef logic [11:0] sbx_addr_t;
endpackage : sbx_pkg

// ===== tb/test_subtract_instruction_exec.sv
// Testbench for the subtract execution block
`timescale 1ns/10ps
module test_subtract_instruction_exec;
	import sbx_pkg::*;
	logic       clk;
	logic       rst_n;
	logic       instr_valid;
	logic       bank_we;
	logic [15:0] instr;
	logic [3:0] bank_wdata;
	logic       instr_ready;
	logic       done;
	logic       illegal;
	logic [7:0] working_register;
	logic [7:0] status;
	logic [7:0] dbg_rdata;
	logic [7:0] ew;
	logic [7:0] es;
	logic [3:0] bank_select_register;
	int         errors;
	int         n_checks;
	sbx_addr_t  dbg_addr;
	logic [7:0] f20;
	logic [7:0] fa90;
	logic [7:0] ff90;

	sbx_core i_sbx_core (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
		.instr(instr), .instr_ready(instr_ready), .done(done),
		.illegal(illegal), .bank_we(bank_we), .bank_wdata(bank_wdata),
		.working_register(working_register), .status(status),
		.bank_select_register(bank_select_register),
		.dbg_addr(dbg_addr), .dbg_rdata(dbg_rdata));

	// ========================================
	// Clock and helpers
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk8

	task chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask : chk1

	task end_sim;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// Offer one word, wait for done under a bound
	task exec(input logic [15:0] w);
		int n;
		instr = w;
		instr_valid = 1'b1;
		@(posedge clk);
		@(negedge clk);
		instr_valid = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 8) begin
			chk1(instr_ready, 1'b0);
			@(negedge clk);
			n++;
		end
		chk8(8'(n), 8'h05);
		if (n == 8)
			end_sim();
	endtask : exec

	// Literal minus working register, expected flags from operands
	task lit(input logic [7:0] k);
		logic [7:0] r;
		r = k - ew;
		es = {3'h0, r[7], (k[7] ^ ew[7]) & (r[7] ^ k[7]), r == 8'h00,
			k[3:0] >= ew[3:0], k >= ew};
		exec({8'h08, k});
		ew = r;
		chk8(working_register, ew);
		chk8(status, es);
		chk1(illegal, 1'b0);
	endtask : lit

	// File forms, expected result and flags from the bench's shadow
	task fop(input logic [15:0] w, input sbx_addr_t a,
		inout logic [7:0] fv);
		logic       fwb;
		logic       b;
		logic [7:0] m;
		logic [7:0] s;
		logic [7:0] r;
		fwb = w[15:10] == 6'h15;
		b = fwb & ~es[0];
		m = fwb ? ew : fv;
		s = fwb ? fv : ew;
		r = m - s - {7'h00, b};
		es = {3'h0, r[7], (m[7] ^ s[7]) & (m[7] ^ r[7]), r == 8'h00,
			{1'b0, m[3:0]} >= {1'b0, s[3:0]} + {4'h0, b},
			{1'b0, m} >= {1'b0, s} + {8'h00, b}};
		exec(w);
		if (w[9])
			fv = r;
		else
			ew = r;
		chk8(working_register, ew);
		chk8(status, es);
		chk1(illegal, 1'b0);
		dbg_addr = a;
		repeat (2) @(negedge clk);
		chk8(dbg_rdata, fv);
	endtask : fop

	// ========================================
	// Scenarios
	task t_lit;
		lit(8'h03);
		lit(8'h02);
		lit(8'hff);
		lit(8'h80);
		lit(8'h01);
		lit(8'h10);
	endtask : t_lit

	task t_illegal;
		exec(16'h0900);
		chk1(illegal, 1'b1);
		chk8(working_register, ew);
		chk8(status, es);
	endtask : t_illegal

	task t_file;
		bank_wdata = 4'ha;
		bank_we = 1'b1;
		@(negedge clk);
		bank_we = 1'b0;
		chk8({4'h0, bank_select_register}, 8'h0a);
		fop(16'h5e20, 12'h020, f20);
		fop(16'h5f90, 12'ha90, fa90);
		fop(16'h5c90, 12'hf90, ff90);
		fop(16'h5620, 12'h020, f20);
	endtask : t_file

	// ========================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		instr_valid = 1'b0;
		instr = 16'h0000;
		bank_we = 1'b0;
		bank_wdata = 4'h0;
		ew = 8'h00;
		es = 8'h00;
		errors = 0;
		n_checks = 0;
		dbg_addr = 12'h000;
		f20 = 8'h00;
		fa90 = 8'h00;
		ff90 = 8'h00;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk8(status, 8'h00);
		chk1(instr_ready, 1'b1);
		chk8(working_register, 8'h00);
		t_lit();
		t_illegal();
		t_file();
		end_sim();
	end
endmodule : test_subtract_instruction_exec
